// ===== logic/windowed_watchdog_regs.sv
/*
 Windowed watchdog: register file, feed checking and event logic.
 Assumes an APB slave port with zero wait states on clk, and a
 counting enable from power control that may come from another domain.
*/
// Overview of operation
// RULE1 - Seven word slots decoded from the base; the code decodes six, and the reserved slot at 0x010 answers with an error
// RULE2 - Two-key feed reloads counter from reload constant
// RULE3 - Mode writes act only after next feed
// RULE4 - Run enable sets once, starts on feed
// RULE5 - Reset enable sets once, gates chip reset
// RULE6 - Timeout, feed error, protection set timeout flag
// RULE7 - Timeout flag with reset enable requests reset
// RULE8 - Timeout flag cleared only by writing zero
// RULE9 - Protected reload write sets timeout flag
// RULE10 - Warning flag set on warning compare match
// RULE11 - Warning flag cleared by reset or zero
// RULE12 - Protection allows reload change below both compares
// RULE13 - Protection sets once, cleared only by reset
// RULE14 - Lock bit drives oscillator lock, set once
// RULE15 - Watchdog reset clears run, reset, protection
// RULE16 - Reload constant 24 bits, resets to minimum
// RULE17 - Counter value readable, resets to minimum
// RULE18 - Window compare resets to all ones
// RULE19 - Warning compare is read-write, resets zero
// RULE20 - Mode used bits reset to zero
// RULE21 - Software writes zeros to reserved bits
// RULE22 - Runs in every state but deepest power-down
// RULE23 - Divide-by-four prescaler, minimum reload enforced
// RULE24 - Warning match on low ten bits, upper zero
// RULE25 - Stray access mid-feed fires event when running
// RULE26 - Early feed in reset mode causes reset
// RULE27 - Interrupt follows warning flag while running
`timescale 1ns/10ps
`default_nettype none
module windowed_watchdog_regs
   import wwdt_pkg::*;
(
   input  wire logic     clk,
   input  wire logic     nrst,
   input  wire apb_req_t apb_i,
   output var  apb_rsp_t apb_o,
   input  wire logic     count_clk_active,
   input  wire logic     deep_powerdown,
   output logic          chip_rst_req,
   output logic          irq_req,
   output logic          osc_lock
);
   logic              acc;
   logic              wr;
   logic              rd_setup;
   logic              hit_mode;
   logic              hit_rel;
   logic              hit_feed;
   logic              hit_count;
   logic              hit_warn;
   logic              hit_win;
   logic              mapped;
   logic              mode_wr;
   logic              rel_wr;
   logic [CW-1:0]     wval;
   logic [CW-1:0]     rel_val;

   mode_bits_t        sh_q;
   mode_bits_t        act_q;
   logic              to_q;
   logic              warn_q;
   logic [CW-1:0]     reload_q;
   logic [WARN_W-1:0] warnc_q;
   logic [CW-1:0]     win_q;
   logic [DW-1:0]     rdata_q;
   logic              ev_q;
   logic              chip_rst_q;
   logic              match_q;
   logic [1:0]        sync1_q;
   logic [1:0]        sync2_q;

   logic              self_rst;
   logic [CW-1:0]     count_q;
   logic              expire;
   logic              armed_q;
   logic              feed_ok;
   logic              feed_bad;
   logic              ferr;
   logic              early;
   logic              prot_ok;
   logic              viol;
   logic              event_w;
   logic              tof_clr;
   logic              warn_clr;
   logic              match;
   logic              cnt_en;
   logic [MODE_W-1:0] mode_rd;
   logic [CW-1:0]     warn_ext;

   // Bus decode; the bus never waits
   assign acc      = apb_i.psel && apb_i.penable;
   assign wr       = acc && apb_i.pwrite;
   assign rd_setup = apb_i.psel && !apb_i.penable && !apb_i.pwrite;

   assign hit_mode  = (apb_i.paddr == OFS_MODE); // [RULE1]
   assign hit_rel   = (apb_i.paddr == OFS_RELOAD); // [RULE1]
   assign hit_feed  = (apb_i.paddr == OFS_FEED); // [RULE1]
   assign hit_count = (apb_i.paddr == OFS_COUNT); // [RULE1]
   assign hit_warn  = (apb_i.paddr == OFS_WARN); // [RULE1]
   assign hit_win   = (apb_i.paddr == OFS_WIN); // [RULE1]
   assign mapped    = hit_mode || hit_rel || hit_feed || hit_count
                      || hit_warn || hit_win;

   assign apb_o = '{prdata: rdata_q, pready: 1'b1, pslverr: acc && !mapped}; // [RULE1]

   assign mode_wr = wr && hit_mode;
   assign rel_wr  = wr && hit_rel;
   assign wval    = apb_i.pwdata[CW-1:0];
   assign rel_val = (wval < MIN_RELOAD) ? MIN_RELOAD : wval; // [RULE23]

   // A watchdog-caused reset is modelled as a one-cycle self clear
   assign self_rst = chip_rst_q;

   // Power-state inputs cross in from clock control
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sync1_q <= 2'h0;
         sync2_q <= 2'h0;
      end else begin
         sync1_q <= {deep_powerdown, count_clk_active};
         sync2_q <= sync1_q;
      end
   end

   // Counting needs a running timer and a live counting clock
   assign cnt_en = act_q.run && sync2_q[0] && !sync2_q[1]; // [RULE22]

   wdt_counter #(
      .PRE (PRESCALE_DIV)
   ) u_counter (
      .clk      (clk),
      .nrst     (nrst),
      .clr      (self_rst),
      .en       (cnt_en),
      .load     (feed_ok),
      .load_val (reload_q),
      .count_q  (count_q),
      .expire   (expire)
   );

   wdt_feed_seq u_feed (
      .clk      (clk),
      .nrst     (nrst),
      .clr      (self_rst),
      .acc      (acc),
      .feed_wr  (wr && hit_feed),
      .wbyte    (apb_i.pwdata[7:0]),
      .armed_q  (armed_q),
      .feed_ok  (feed_ok),
      .feed_bad (feed_bad)
   );

   // Feed errors are ignored until the timer has been started
   assign ferr  = feed_bad && act_q.run; // [RULE25]
   assign early = feed_ok && act_q.run && act_q.rst_en
                  && (count_q > win_q); // [RULE26]

   assign warn_ext = {{(CW - WARN_W){1'b0}}, warnc_q};
   assign prot_ok  = (count_q < warn_ext) && (count_q < win_q); // [RULE12]
   assign viol     = rel_wr && act_q.prot && !prot_ok; // [RULE9]

   assign event_w  = expire || ferr || early || viol; // [RULE6]
   assign tof_clr  = mode_wr && !apb_i.pwdata[B_TOF];
   assign warn_clr = mode_wr && !apb_i.pwdata[B_WARNF];

   // Bits of the counter above the compare field must be zero
   assign match = act_q.run
                  && (count_q[CW-1:WARN_W] == '0)
                  && (count_q[WARN_W-1:0] == warnc_q); // [RULE24]

   // Written mode bits; set-once, software cannot clear them
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sh_q <= '0; // [RULE20]
      end else if (self_rst) begin
         sh_q <= '0; // [RULE15] [RULE14]
      end else if (mode_wr) begin
         sh_q.run    <= sh_q.run    | apb_i.pwdata[B_RUN]; // [RULE4]
         sh_q.rst_en <= sh_q.rst_en | apb_i.pwdata[B_RSTEN]; // [RULE5]
         sh_q.prot   <= sh_q.prot   | apb_i.pwdata[B_PROT]; // [RULE13]
         sh_q.lock   <= sh_q.lock   | apb_i.pwdata[B_LOCK]; // [RULE14]
      end
   end

   // Operating copy, refreshed only by a good feed
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         act_q <= '0;
      end else if (self_rst) begin
         act_q <= '0; // [RULE15]
      end else if (feed_ok) begin
         act_q <= sh_q; // [RULE3] [RULE4]
      end
   end

   // Survives a watchdog reset so the cause stays readable
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         to_q <= 1'b0;
      end else if (event_w) begin
         to_q <= 1'b1; // [RULE6] [RULE9]
      end else if (tof_clr) begin
         to_q <= 1'b0; // [RULE8]
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         match_q <= 1'b0;
      end else begin
         match_q <= match;
      end
   end

   // In interrupt mode an event also raises the warning
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         warn_q <= 1'b0;
      end else if (self_rst) begin
         warn_q <= 1'b0; // [RULE11]
      end else if ((match && !match_q)
                   || (event_w && !act_q.rst_en && act_q.run)) begin
         warn_q <= 1'b1; // [RULE10] [RULE24]
      end else if (warn_clr) begin
         warn_q <= 1'b0; // [RULE11]
      end
   end

   // A refused write keeps the old constant
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         reload_q <= RST_RELOAD; // [RULE16]
      end else if (self_rst) begin
         reload_q <= RST_RELOAD;
      end else if (rel_wr && !viol) begin
         reload_q <= rel_val; // [RULE12] [RULE23]
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         warnc_q <= RST_WARN; // [RULE19]
      end else if (self_rst) begin
         warnc_q <= RST_WARN;
      end else if (wr && hit_warn) begin
         warnc_q <= apb_i.pwdata[WARN_W-1:0];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         win_q <= RST_WIN; // [RULE18]
      end else if (self_rst) begin
         win_q <= RST_WIN;
      end else if (wr && hit_win) begin
         win_q <= wval;
      end
   end

   // Chip reset lands on the second clock after the event
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ev_q       <= 1'b0;
         chip_rst_q <= 1'b0;
      end else begin
         ev_q       <= event_w && !self_rst;
         chip_rst_q <= ev_q && act_q.rst_en && !chip_rst_q; // [RULE7] [RULE5]
      end
   end

   // Mode reads show the written bits and both flags
   always_comb begin
      mode_rd          = '0;
      mode_rd[B_RUN]   = sh_q.run;
      mode_rd[B_RSTEN] = sh_q.rst_en;
      mode_rd[B_TOF]   = to_q;
      mode_rd[B_WARNF] = warn_q;
      mode_rd[B_PROT]  = sh_q.prot;
      mode_rd[B_LOCK]  = sh_q.lock;
   end

   // Read data is captured in the setup phase; reserved bits read zero
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= '0;
      end else if (rd_setup) begin
         case (1'b1)
            hit_mode: begin
               rdata_q <= {{(DW - MODE_W){1'b0}}, mode_rd};
            end
            hit_rel: begin
               rdata_q <= {{(DW - CW){1'b0}}, reload_q};
            end
            hit_count: begin
               rdata_q <= {{(DW - CW){1'b0}}, count_q}; // [RULE17]
            end
            hit_warn: begin
               rdata_q <= {{(DW - WARN_W){1'b0}}, warnc_q};
            end
            hit_win: begin
               rdata_q <= {{(DW - CW){1'b0}}, win_q};
            end
            default: begin
               rdata_q <= '0;
            end
         endcase
      end
   end

   assign chip_rst_req = chip_rst_q;
   assign irq_req      = warn_q && act_q.run; // [RULE27]
   assign osc_lock     = act_q.lock; // [RULE14]

   a_tof_on_event: assert property (@(posedge clk) disable iff (!nrst)
      event_w |=> to_q) // [RULE6]
      else $error("Timeout flag not set by an event");

   a_chip_rst_gate: assert property (@(posedge clk) disable iff (!nrst)
      event_w && act_q.rst_en && !ev_q && !chip_rst_q
      |-> ##2 chip_rst_q) // [RULE7]
      else $error("Chip reset missing two cycles after event");

   a_rst_needs_en: assert property (@(posedge clk) disable iff (!nrst)
      chip_rst_q |-> act_q.rst_en) // [RULE5]
      else $error("Chip reset without reset enable");

   a_tof_sticky: assert property (@(posedge clk) disable iff (!nrst)
      to_q && !tof_clr |=> to_q) // [RULE8]
      else $error("Timeout flag dropped without a zero write");

   a_viol_keeps: assert property (@(posedge clk) disable iff (!nrst)
      viol && !self_rst |=> to_q && reload_q == $past(reload_q)) // [RULE12]
      else $error("Protected reload changed or not flagged");

   a_mode_defer: assert property (@(posedge clk) disable iff (!nrst)
      !feed_ok && !self_rst |=> act_q == $past(act_q)) // [RULE3]
      else $error("Mode took effect without a feed");

   a_warn_match: assert property (@(posedge clk) disable iff (!nrst)
      match && !match_q && !self_rst |=> warn_q) // [RULE10]
      else $error("Warning flag missed a compare match");

   a_min_reload: assert property (@(posedge clk) disable iff (!nrst)
      reload_q >= MIN_RELOAD) // [RULE23]
      else $error("Reload constant below the minimum");

   a_feed_err: assert property (@(posedge clk) disable iff (!nrst)
      feed_bad && act_q.run |=> to_q) // [RULE25]
      else $error("Feed error did not set the timeout flag");

   a_irq_follow: assert property (@(posedge clk) disable iff (!nrst)
      warn_clr && !match && !event_w |=> !irq_req) // [RULE27]
      else $error("Interrupt stayed up after the flag was cleared");

endmodule // windowed_watchdog_regs
`default_nettype wire

// ===== logic/wwdt_pkg.sv
/*
 Shared constants and carriers of the windowed watchdog.
 Assumes a single 100 MHz clock and an APB-style register port.
*/
package wwdt_pkg;
   localparam int unsigned AW       = 12;
   localparam int unsigned DW       = 32;
   localparam int unsigned CW       = 24;
   localparam int unsigned WARN_W   = 10;
   localparam int unsigned MODE_W   = 6;

   localparam logic [AW-1:0] OFS_MODE   = 12'h000;
   localparam logic [AW-1:0] OFS_RELOAD = 12'h004;
   localparam logic [AW-1:0] OFS_FEED   = 12'h008;
   localparam logic [AW-1:0] OFS_COUNT  = 12'h00C;
   localparam logic [AW-1:0] OFS_RSVD   = 12'h010;
   localparam logic [AW-1:0] OFS_WARN   = 12'h014;
   localparam logic [AW-1:0] OFS_WIN    = 12'h018;

   localparam int unsigned B_RUN   = 0;
   localparam int unsigned B_RSTEN = 1;
   localparam int unsigned B_TOF   = 2;
   localparam int unsigned B_WARNF = 3;
   localparam int unsigned B_PROT  = 4;
   localparam int unsigned B_LOCK  = 5;

   localparam logic [CW-1:0]     RST_RELOAD = 24'h0000FF;
   localparam logic [CW-1:0]     MIN_RELOAD = 24'h0000FF;
   localparam logic [CW-1:0]     RST_COUNT  = 24'h0000FF;
   localparam logic [CW-1:0]     RST_WIN    = 24'hFFFFFF;
   localparam logic [WARN_W-1:0] RST_WARN   = 10'h000;

   localparam logic [7:0] FEED_KEY1 = 8'hAA;
   localparam logic [7:0] FEED_KEY2 = 8'h55;

   localparam int unsigned PRESCALE_DIV = 4;

   typedef struct packed {
      logic          psel;
      logic          penable;
      logic          pwrite;
      logic [AW-1:0] paddr;
      logic [DW-1:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic [DW-1:0] prdata;
      logic          pready;
      logic          pslverr;
   } apb_rsp_t;

   typedef struct packed {
      logic lock;
      logic prot;
      logic rst_en;
      logic run;
   } mode_bits_t;
endpackage

// ===== logic/wdt_counter.sv
/*
 Prescaled 24-bit down-counter of the watchdog.
 Assumes load and enable come from logic on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module wdt_counter
   import wwdt_pkg::*;
#(
   parameter int unsigned PRE = PRESCALE_DIV
) (
   input  wire logic          clk,
   input  wire logic          nrst,
   input  wire logic          clr,
   input  wire logic          en,
   input  wire logic          load,
   input  wire logic [CW-1:0] load_val,
   output logic      [CW-1:0] count_q,
   output logic               expire
);
   localparam int unsigned PW = (PRE > 1) ? $clog2(PRE) : 1;
   localparam logic [PW-1:0] PRE_LAST = PW'(PRE - 1);

   logic [PW-1:0] pre_q;
   logic          tick;

   assign tick   = en && (count_q != '0) && (pre_q == PRE_LAST);
   assign expire = tick && (count_q == CW'(1));

   // Fixed divide-by-four ahead of the counter
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pre_q <= '0;
      end else if (clr || load || tick) begin
         pre_q <= '0; // [RULE23]
      end else if (en && count_q != '0) begin
         pre_q <= pre_q + PW'(1);
      end
   end

   // Holds at zero once expired; only a feed restarts it
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         count_q <= RST_COUNT;
      end else if (clr) begin
         count_q <= RST_COUNT;
      end else if (load) begin
         count_q <= load_val;
      end else if (tick) begin
         count_q <= count_q - CW'(1); // [RULE23]
      end
   end

   a_count_step: assert property (@(posedge clk) disable iff (!nrst)
      tick && !clr && !load |=> count_q == $past(count_q) - CW'(1)) // [RULE23]
      else $error("Counter did not step down by one");

endmodule // wdt_counter
`default_nettype wire

// ===== logic/wdt_feed_seq.sv
/*
 Feed sequence tracker: first key, then second key.
 Assumes acc marks each completed register access, one cycle each.
*/
`timescale 1ns/10ps
`default_nettype none
module wdt_feed_seq
   import wwdt_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       clr,
   input  wire logic       acc,
   input  wire logic       feed_wr,
   input  wire logic [7:0] wbyte,
   output logic            armed_q,
   output logic            feed_ok,
   output logic            feed_bad
);
   logic key1;
   logic key2;

   assign key1     = acc && feed_wr && (wbyte == FEED_KEY1);
   assign key2     = acc && feed_wr && (wbyte == FEED_KEY2);
   assign feed_ok  = armed_q && key2; // [RULE2]
   assign feed_bad = armed_q && acc && !key2; // [RULE25]

   // Any access after the first key ends the sequence
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         armed_q <= 1'b0;
      end else if (clr) begin
         armed_q <= 1'b0;
      end else if (armed_q && acc) begin
         armed_q <= 1'b0;
      end else if (key1) begin
         armed_q <= 1'b1; // [RULE2]
      end
   end

   a_feed_pair: assert property (@(posedge clk) disable iff (!nrst)
      feed_ok |-> $past(key1) || !$past(acc)) // [RULE2]
      else $error("Feed accepted without a leading first key");

endmodule // wdt_feed_seq
`default_nettype wire

// ===== verif/apb_sw_model.sv
/*
 Software side of the watchdog: an APB master that runs one transfer at a time.
 Assumes zero-wait responses are normal; a stuck pready raises hung.
*/
`timescale 1ns/10ps
`default_nettype none
module apb_sw_model
   import wwdt_pkg::*;
(
   input  wire apb_rsp_t rsp,
   input  wire logic     clk,
   output var  apb_req_t req,
   output logic          hung
);
   initial begin
      req  = '0;
      hung = 1'b0;
   end

   // Data words keep reserved bits at zero
   task automatic xfer(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d,
                       output logic [DW-1:0] q, output logic err);
      int n;
      @(negedge clk);
      req.psel    = 1'b1;
      req.pwrite  = w;
      req.paddr   = a;
      req.pwdata  = d;
      @(negedge clk);
      req.penable = 1'b1;
      for (n = 0; n < 8; n++) begin
         @(posedge clk);
         if (rsp.pready === 1'b1) break;
      end
      if (n == 8) hung = 1'b1;
      q   = rsp.prdata;
      err = rsp.pslverr;
      @(negedge clk);
      // Released lines show the inverse so a stale value never looks valid
      req.psel    = 1'b0;
      req.penable = 1'b0;
      req.paddr   = ~a;
      req.pwdata  = ~d;
   endtask

   // Both keys with nothing in between
   task automatic feed();
      logic [DW-1:0] q;
      logic          e;
      xfer(1'b1, OFS_FEED, {24'h0, FEED_KEY1}, q, e);
      xfer(1'b1, OFS_FEED, {24'h0, FEED_KEY2}, q, e);
   endtask
endmodule // apb_sw_model
`default_nettype wire

// ===== verif/windowed_watchdog_regs_tb_top.sv
/*
 Self-checking bench of the windowed watchdog register block.
 Assumes the software model in apb_sw_model and a 100 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module windowed_watchdog_regs_tb_top
   import wwdt_pkg::*;
;
   logic          clk;
   logic          nrst;
   logic          ck_act;
   logic          deep;
   apb_req_t      req;
   apb_rsp_t      rsp;
   logic          rst_req;
   logic          irq;
   logic          lock;
   logic          hung;
   int            n_errors;
   int            n_tests;
   int            n_rst;
   logic [DW-1:0] q;
   logic          e;

   windowed_watchdog_regs dut (.clk(clk), .nrst(nrst), .apb_i(req), .apb_o(rsp),
      .count_clk_active(ck_act), .deep_powerdown(deep), .chip_rst_req(rst_req),
      .irq_req(irq), .osc_lock(lock));
   apb_sw_model sw (.rsp(rsp), .clk(clk), .req(req), .hung(hung));

   initial clk = 1'b0;
   always #5 clk = ~clk;

   // Pulses are one cycle wide, so count them rather than poll
   always @(posedge clk) begin
      if (rst_req === 1'b1) n_rst++;
   end

   task automatic end_of_test();
      $display("errors %0d tests %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
      sw.xfer(1'b1, a, d, q, e);
      if (hung === 1'b1) begin
         n_errors++;
         end_of_test();
      end
   endtask

   task automatic rdc(input logic [AW-1:0] a, input logic [DW-1:0] exp);
      sw.xfer(1'b0, a, 32'h0, q, e);
      if (hung === 1'b1) begin
         n_errors++;
         end_of_test();
      end
      chk(q, exp);
      chk({31'h0, e}, 32'h0);
   endtask

   task automatic wait_rst(input int max, output int n);
      for (n = 0; n < max; n++) begin
         @(posedge clk);
         #1;
         if (rst_req === 1'b1) break;
      end
      if (n == max) begin
         chk(32'h0, 32'h1);
         end_of_test();
      end
      // Let the self reset cycle pass before software touches the bus
      @(negedge clk);
   endtask

   task automatic s_reset_values();
      rdc(OFS_MODE, 32'h0);
      rdc(OFS_RELOAD, {8'h0, RST_RELOAD});
      rdc(OFS_COUNT, {8'h0, RST_COUNT});
      rdc(OFS_WARN, 32'h0);
      rdc(OFS_WIN, {8'h0, RST_WIN});
      rdc(OFS_FEED, 32'h0);
      sw.xfer(1'b0, OFS_RSVD, 32'h0, q, e);
      chk({31'h0, e}, 32'h1);
      sw.xfer(1'b0, 12'h01C, 32'h0, q, e);
      chk({31'h0, e}, 32'h1);
      chk({29'h0, rst_req, irq, lock}, 32'h0);
   endtask

   task automatic s_mode_shadow();
      wr(OFS_MODE, 32'h1);
      wr(OFS_MODE, 32'h0);
      rdc(OFS_MODE, 32'h1);
      repeat (40) @(negedge clk);
      rdc(OFS_COUNT, 32'hFF);
      wr(OFS_RELOAD, 32'h10);
      rdc(OFS_RELOAD, 32'hFF);
      wr(OFS_RELOAD, 32'h300);
      wr(OFS_WARN, 32'h2F0);
      rdc(OFS_WARN, 32'h2F0);
   endtask

   task automatic s_feed_count();
      logic [DW-1:0] a;
      sw.feed();
      repeat (200) @(negedge clk);
      sw.xfer(1'b0, OFS_COUNT, 32'h0, q, e);
      chk({31'h0, (q >= 32'h2CA && q <= 32'h2D1)}, 32'h1);
      rdc(OFS_MODE, 32'h9);
      chk({31'h0, irq}, 32'h1);
      deep = 1'b1;
      repeat (10) @(negedge clk);
      sw.xfer(1'b0, OFS_COUNT, 32'h0, a, e);
      repeat (100) @(negedge clk);
      rdc(OFS_COUNT, a);
      deep   = 1'b0;
      ck_act = 1'b0;
      repeat (10) @(negedge clk);
      sw.xfer(1'b0, OFS_COUNT, 32'h0, a, e);
      repeat (100) @(negedge clk);
      rdc(OFS_COUNT, a);
      ck_act = 1'b1;
      wr(OFS_MODE, 32'h1);
      chk({31'h0, irq}, 32'h0);
   endtask

   task automatic s_feed_error();
      wr(OFS_FEED, 32'hAA);
      wr(OFS_WARN, 32'h2F0);
      rdc(OFS_MODE, 32'hD);
      chk(n_rst, 32'h0);
      wr(OFS_MODE, 32'h1);
      rdc(OFS_MODE, 32'h1);
   endtask

   task automatic s_protect();
      wr(OFS_MODE, 32'h11);
      sw.feed();
      wr(OFS_RELOAD, 32'h400);
      rdc(OFS_RELOAD, 32'h300);
      rdc(OFS_MODE, 32'h1D);
      wr(OFS_MODE, 32'h1);
      rdc(OFS_MODE, 32'h11);
      repeat (80) @(negedge clk);
      wr(OFS_RELOAD, 32'h280);
      rdc(OFS_RELOAD, 32'h280);
   endtask

   task automatic s_early_feed();
      int n;
      wr(OFS_MODE, 32'h33);
      chk({31'h0, lock}, 32'h0);
      sw.feed();
      chk({31'h0, lock}, 32'h1);
      wr(OFS_WIN, 32'h100);
      sw.feed();
      wait_rst(20, n);
      rdc(OFS_MODE, 32'h4);
      chk({31'h0, lock}, 32'h0);
   endtask

   task automatic s_expiry();
      int n;
      wr(OFS_MODE, 32'h3);
      rdc(OFS_MODE, 32'h3);
      sw.feed();
      wait_rst(1100, n);
      // 255 steps of four clocks, plus sync and pipeline slack
      chk({31'h0, (n >= 1010 && n <= 1035)}, 32'h1);
      rdc(OFS_MODE, 32'h4);
      chk(n_rst, 32'h2);
   endtask

   task automatic s_ext_reset();
      nrst = 1'b0;
      repeat (2) @(negedge clk);
      nrst = 1'b1;
      rdc(OFS_MODE, 32'h0);
   endtask

   initial begin
      n_errors = 0;
      n_tests  = 0;
      n_rst    = 0;
      nrst     = 1'b0;
      ck_act   = 1'b1;
      deep     = 1'b0;
      repeat (2) @(negedge clk);
      nrst = 1'b1;
      s_reset_values();
      s_mode_shadow();
      s_feed_count();
      s_feed_error();
      s_protect();
      s_early_feed();
      s_expiry();
      s_ext_reset();
      end_of_test();
   end
endmodule // windowed_watchdog_regs_tb_top
`default_nettype wire
